//--- src/alc_pkg.sv
package alc_pkg;

   // ----------------------------------------------------------------
   // apb register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SET_A = 8'h04;
   localparam logic [7:0] OFS_SET_B = 8'h08;
   localparam logic [7:0] OFS_MAN_A = 8'h0c;
   localparam logic [7:0] OFS_MAN_B = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;

   // control register bit positions
   localparam int CTRL_EN_A = 0;
   localparam int CTRL_EN_B = 1;
   localparam int CTRL_LINK = 2;
   localparam int CTRL_FAST = 3;
   localparam int CTRL_BIAS_A = 4;
   localparam int CTRL_BIAS_B = 5;
   localparam int CTRL_PWR_AL = 8;
   localparam int CTRL_PWR_AR = 9;
   localparam int CTRL_PWR_BL = 10;
   localparam int CTRL_PWR_BR = 11;
   localparam int CTRL_W = 12;
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

   // ----------------------------------------------------------------
   // per-pair settings, held in bits [21:0] of a settings register
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ref_lvl;
      logic [1:0] fast_recovery_speed;
      logic [1:0] recovery_step_sel;
      logic [2:0] recovery_wait_sel;
      logic [1:0] zero_cross_timeout_sel;
      logic [1:0] atten_step_sel;
      logic zero_cross_disable;
      logic [1:0] limit_threshold_sel;
   } alc_set_t;
   localparam int SET_W = 22;
   localparam logic [SET_W-1:0] SET_RST = 22'h384000;

   // one volume code per channel of a pair
   typedef struct packed {
      logic [7:0] right_volume;
      logic [7:0] left_volume;
   } alc_vol_t;
   localparam logic [15:0] MAN_RST = 16'h9191;

   // four converted samples: 0 a-left, 1 a-right, 2 b-left, 3 b-right
   typedef struct packed {
      logic [3:0][15:0] ch;
   } alc_samples_t;

   // ----------------------------------------------------------------
   // volume codes, levels and timing in sample periods
   // ----------------------------------------------------------------
   localparam logic [7:0] VOL_MAX = 8'hf1;
   localparam logic [7:0] VOL_MUTE = 8'h00;
   localparam logic [15:0] LVL_FULL = 16'h7fff;
   localparam logic [15:0] LVL_M2P5 = 16'h5fff;
   localparam logic [15:0] LVL_M4P1 = 16'h4fd5;
   localparam logic [15:0] LVL_M6P0 = 16'h4027;
   localparam logic [15:0] LVL_M8P5 = 16'h301b;
   localparam logic [15:0] LVL_M12 = 16'h2027;
   localparam logic [10:0] ZC_BASE_FS = 11'h080;
   localparam logic [14:0] WAIT_BASE_FS = 15'h0080;
   localparam logic [15:0] IMPULSE_MAX_FS = 16'h0008;

   typedef enum logic [3:0] {
      ST_MANUAL = 4'b0001,
      ST_LIMIT = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_RECOVER = 4'b1000
   } alc_state_t;

endpackage

//--- src/alc_level_ctrl.sv
// Functional notes
// - pair a enable runs level control on both pair a channels; pair b alike.
// - while running, a pair's left and right volumes are always identical.
// - link-all at 0: per-pair manual or 2-channel; at 1 all four share one volume.
// - in 4-channel mode all settings come from pair a; pair b settings ignored.
// - 2-channel mode: either channel at detection level attenuates both pair volumes.
// - 4-channel mode: any of four channels at detection attenuates shared volume.
// - threshold code picks -2.5/-4.1/-6.0/-8.5 dBFS; band down to next, -12 lowest.
// - zero-cross enabled: limiter steps at a zero crossing or on timeout.
// - attenuation step 1/2/4/8 steps; forced to 1 with zero-cross disabled.
// - zero-cross disabled: limiter updates within one sample period.
// - fast limiter: full-scale sample drops volume one step within one sample.
// - timeout code sets 128/256/512/1024 sample periods for limit and recovery.
// - keep attenuating while at or above detection; restart later unless manual.
// - wait 128..16384 sample periods after limiting, only while below band.
// - recovery raises both volumes 1..4 steps, never beyond the reference level.
// - one increment per waiting period, or per timeout when that is longer.
// - reference code f1 is +36 dB down to 01, 00 mute; default e1.
// - output inside reset band restarts waiting timer; below it the timer runs.
// - after an impulse recovery runs 4, 8 or 16 times faster; code 11 unused.
// - mic bias enable at 1 drives its bias output; at 0 it floats.
`timescale 1ns/1ps
`default_nettype none

module alc_level_ctrl
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [alc_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sample_valid_i,
   input wire alc_pkg::alc_samples_t samples_i,
   output alc_pkg::alc_vol_t vol_a_o,
   output alc_pkg::alc_vol_t vol_b_o,
   output logic mic_bias_out_a_o,
   output logic mic_bias_out_a_oe_o,
   output logic mic_bias_out_b_o,
   output logic mic_bias_out_b_oe_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] mag(input logic [15:0] s);
      mag = s[15] ? 16'(~s + 16'h0001) : s;
   endfunction

   function automatic logic [15:0] thr_of(input logic [1:0] sel);
      case (sel)
         2'h0: thr_of = alc_pkg::LVL_M2P5;
         2'h1: thr_of = alc_pkg::LVL_M4P1;
         2'h2: thr_of = alc_pkg::LVL_M6P0;
         default: thr_of = alc_pkg::LVL_M8P5;
      endcase
   endfunction

   // lower edge of the band that keeps the waiting timer in reset
   function automatic logic [15:0] band_of(input logic [1:0] sel);
      case (sel)
         2'h0: band_of = alc_pkg::LVL_M4P1;
         2'h1: band_of = alc_pkg::LVL_M6P0;
         2'h2: band_of = alc_pkg::LVL_M8P5;
         default: band_of = alc_pkg::LVL_M12;
      endcase
   endfunction

   function automatic logic [7:0] dec_vol(input logic [7:0] v, input logic [7:0] n);
      dec_vol = (v > n) ? 8'(v - n) : alc_pkg::VOL_MUTE;
   endfunction

   // saturates at the reference; a volume already above it is left alone
   function automatic logic [7:0] inc_vol(input logic [7:0] v, input logic [7:0] n, input logic [7:0] r);
      logic [8:0] sum;
      sum = {1'b0, v} + {1'b0, n};
      if (v >= r)
         inc_vol = v;
      else if (sum > {1'b0, r})
         inc_vol = r;
      else
         inc_vol = sum[7:0];
   endfunction

   function automatic logic [14:0] wait_len(input logic [2:0] sel, input logic imp, input logic [1:0] spd);
      logic [14:0] base;
      base = alc_pkg::WAIT_BASE_FS << sel;
      if (!imp || spd == 2'h3)
         wait_len = base;
      else
         // widened so that code 10 shifts by four instead of wrapping to zero
         wait_len = base >> (3'(spd) + 3'h2);
   endfunction

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic [alc_pkg::CTRL_W-1:0] ctrl_reg;
   alc_pkg::alc_set_t set_reg [2];
   alc_pkg::alc_vol_t man_reg [2];
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   alc_pkg::alc_vol_t vol_a_reg;
   alc_pkg::alc_vol_t vol_b_reg;
   logic [1:0] bias_reg;
   logic [3:0] sign_reg;
   alc_pkg::alc_state_t state_reg [2];
   logic [7:0] vol_reg [2];
   logic [10:0] zc_cnt_reg [2];
   logic [14:0] wait_cnt_reg [2];
   logic [15:0] lim_len_reg [2];
   logic [1:0] impulse_reg;
   logic link;
   logic access;
   logic hit;
   logic [31:0] rd_mux;
   alc_pkg::alc_set_t set_eff [2];
   logic [1:0] run;
   logic [1:0] over_g;
   logic [1:0] clip_g;
   logic [1:0] band_g;
   logic [1:0] zc_g;
   logic [1:0] zc_hit;
   logic [1:0] fast_hit;
   logic [7:0] att_n [2];

   assign link = ctrl_reg[alc_pkg::CTRL_LINK];
   assign access = psel_i && penable_i;

   // ----------------------------------------------------------------
   // apb slave: one wait state, so read data comes from a flop
   // ----------------------------------------------------------------
   always_comb
   begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr_i)
         alc_pkg::OFS_CTRL: rd_mux = 32'(ctrl_reg);
         alc_pkg::OFS_SET_A: rd_mux = 32'(set_reg[0]);
         alc_pkg::OFS_SET_B: rd_mux = 32'(set_reg[1]);
         alc_pkg::OFS_MAN_A: rd_mux = 32'(man_reg[0]);
         alc_pkg::OFS_MAN_B: rd_mux = 32'(man_reg[1]);
         alc_pkg::OFS_STAT: rd_mux = {8'h00, state_reg[1], state_reg[0], vol_reg[1], vol_reg[0]};
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= access && !pready_reg;
         pslverr_reg <= access && !pready_reg && !hit;
         prdata_reg <= (access && !pready_reg && !pwrite_i && hit) ? rd_mux : 32'h0000_0000;
      end
   end

   // register writes land on the edge that completes the access
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         ctrl_reg <= alc_pkg::CTRL_RST;
         set_reg[0] <= alc_pkg::SET_RST; // reference defaults to e1
         set_reg[1] <= alc_pkg::SET_RST;
         man_reg[0] <= alc_pkg::MAN_RST;
         man_reg[1] <= alc_pkg::MAN_RST;
      end
      else if (access && pready_reg && pwrite_i)
      begin
         case (paddr_i)
            alc_pkg::OFS_CTRL: ctrl_reg <= pwdata_i[alc_pkg::CTRL_W-1:0];
            alc_pkg::OFS_SET_A: set_reg[0] <= pwdata_i[alc_pkg::SET_W-1:0];
            alc_pkg::OFS_SET_B: set_reg[1] <= pwdata_i[alc_pkg::SET_W-1:0];
            alc_pkg::OFS_MAN_A: man_reg[0] <= pwdata_i[15:0];
            alc_pkg::OFS_MAN_B: man_reg[1] <= pwdata_i[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // level detection per control group
   // ----------------------------------------------------------------
   // in link mode group 0 watches all four channels and group 1 idles;
   // software is trusted not to flip link or power one pair alone
   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         set_eff[p] = (link || p == 0) ? set_reg[0] : set_reg[1];
         over_g[p] = 1'b0;
         clip_g[p] = 1'b0;
         band_g[p] = 1'b0;
         zc_g[p] = 1'b0;
         for (int c = 0; c < 4; c++)
         begin
            if (link ? (p == 0) : (c / 2 == p))
            begin
               over_g[p] = over_g[p] || (mag(samples_i.ch[c]) >= thr_of(set_eff[p].limit_threshold_sel));
               clip_g[p] = clip_g[p] || (mag(samples_i.ch[c]) >= alc_pkg::LVL_FULL);
               band_g[p] = band_g[p] || (mag(samples_i.ch[c]) >= band_of(set_eff[p].limit_threshold_sel));
               zc_g[p] = zc_g[p] || (sign_reg[c] != samples_i.ch[c][15]);
            end
         end
         band_g[p] = band_g[p] && !over_g[p];
         run[p] = (link ? (p == 0) : ctrl_reg[alc_pkg::CTRL_EN_A + p])
            && (link ? (ctrl_reg[alc_pkg::CTRL_PWR_BR:alc_pkg::CTRL_PWR_AL] != 4'h0)
               : (ctrl_reg[alc_pkg::CTRL_PWR_AL + 2 * p] || ctrl_reg[alc_pkg::CTRL_PWR_AR + 2 * p]));
         // a step is due at a crossing or when the timeout runs out
         zc_hit[p] = zc_g[p] || (zc_cnt_reg[p] >= 11'((alc_pkg::ZC_BASE_FS << set_eff[p].zero_cross_timeout_sel) - 11'h001));
         fast_hit[p] = ctrl_reg[alc_pkg::CTRL_FAST] && clip_g[p];
         att_n[p] = set_eff[p].zero_cross_disable ? 8'h01 : (8'h01 << set_eff[p].atten_step_sel);
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         sign_reg <= 4'h0;
      else if (sample_valid_i)
         for (int c = 0; c < 4; c++)
            sign_reg[c] <= samples_i.ch[c][15];
   end

   // ----------------------------------------------------------------
   // limiter / recovery engine, one per group, stepped once per sample
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (reset_i || !run[p])
         begin
            // the left manual code is the start value when control begins
            state_reg[p] <= alc_pkg::ST_MANUAL;
            vol_reg[p] <= man_reg[p].left_volume;
            zc_cnt_reg[p] <= 11'h000;
            wait_cnt_reg[p] <= 15'h0000;
            lim_len_reg[p] <= 16'h0000;
            impulse_reg[p] <= 1'b0;
         end
         else if (sample_valid_i)
         begin
            zc_cnt_reg[p] <= zc_hit[p] ? 11'h000 : 11'(zc_cnt_reg[p] + 11'h001);
            if (fast_hit[p] || over_g[p])
            begin
               // keep cutting until the level falls below the threshold
               state_reg[p] <= alc_pkg::ST_LIMIT;
               wait_cnt_reg[p] <= 15'h0000;
               if (lim_len_reg[p] != 16'hffff)
                  lim_len_reg[p] <= 16'(lim_len_reg[p] + 16'h0001);
               if (fast_hit[p] || set_eff[p].zero_cross_disable)
                  vol_reg[p] <= dec_vol(vol_reg[p], 8'h01);
               else if (zc_hit[p])
                  vol_reg[p] <= dec_vol(vol_reg[p], att_n[p]);
            end
            else
            begin
               case (state_reg[p])
                  alc_pkg::ST_MANUAL:
                  begin
                     state_reg[p] <= alc_pkg::ST_WAIT;
                  end
                  alc_pkg::ST_LIMIT:
                  begin
                     // a short burst of limiting counts as impulse noise
                     state_reg[p] <= alc_pkg::ST_WAIT;
                     impulse_reg[p] <= (lim_len_reg[p] <= alc_pkg::IMPULSE_MAX_FS);
                     lim_len_reg[p] <= 16'h0000;
                  end
                  alc_pkg::ST_WAIT:
                  begin
                     if (band_g[p])
                        wait_cnt_reg[p] <= 15'h0000;
                     else if (wait_cnt_reg[p] >= 15'(wait_len(set_eff[p].recovery_wait_sel, impulse_reg[p],
                        set_eff[p].fast_recovery_speed) - 15'h0001))
                        state_reg[p] <= alc_pkg::ST_RECOVER;
                     else
                        wait_cnt_reg[p] <= 15'(wait_cnt_reg[p] + 15'h0001);
                  end
                  alc_pkg::ST_RECOVER:
                  begin
                     // the timeout counter ran through the wait, so a long
                     // timeout paces the increments instead of the wait
                     if (band_g[p])
                     begin
                        state_reg[p] <= alc_pkg::ST_WAIT;
                        wait_cnt_reg[p] <= 15'h0000;
                     end
                     else if (zc_hit[p])
                     begin
                        vol_reg[p] <= inc_vol(vol_reg[p], 8'(set_eff[p].recovery_step_sel) + 8'h01,
                           set_eff[p].ref_lvl);
                        state_reg[p] <= alc_pkg::ST_WAIT;
                        wait_cnt_reg[p] <= 15'h0000;
                        if (vol_reg[p] >= set_eff[p].ref_lvl)
                           impulse_reg[p] <= 1'b0;
                     end
                  end
                  default:
                  begin
                     state_reg[p] <= alc_pkg::ST_MANUAL;
                  end
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // channel volumes and bias pins
   // ----------------------------------------------------------------
   // one shared code per running pair keeps left and right in step
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         vol_a_reg <= alc_pkg::MAN_RST;
         vol_b_reg <= alc_pkg::MAN_RST;
      end
      else
      begin
         vol_a_reg <= run[0] ? {vol_reg[0], vol_reg[0]} : man_reg[0];
         if (link && run[0])
            vol_b_reg <= {vol_reg[0], vol_reg[0]};
         else
            vol_b_reg <= run[1] ? {vol_reg[1], vol_reg[1]} : man_reg[1];
      end
   end

   // bias pins float unless enabled
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         bias_reg <= 2'h0;
      else
         bias_reg <= {ctrl_reg[alc_pkg::CTRL_BIAS_B], ctrl_reg[alc_pkg::CTRL_BIAS_A]};
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign vol_a_o = vol_a_reg;
   assign vol_b_o = vol_b_reg;
   assign mic_bias_out_a_o = bias_reg[0];
   assign mic_bias_out_a_oe_o = bias_reg[0];
   assign mic_bias_out_b_o = bias_reg[1];
   assign mic_bias_out_b_oe_o = bias_reg[1];

   // ----------------------------------------------------------------
   // assertions (group 0 stands for both)
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_cut_one;
      sample_valid_i && run[0] && vol_reg[0] > 8'h01 && (fast_hit[0]
         || (over_g[0] && set_eff[0].zero_cross_disable));
   endsequence

   sequence s_raise;
      run[0] && $past(run[0]) && $past(state_reg[0] == alc_pkg::ST_RECOVER) ##0 vol_reg[0] > $past(vol_reg[0]);
   endsequence

   AST_PAIR_EQUAL: assert property (run[0] ##1 run[0] |=> vol_a_o.left_volume == vol_a_o.right_volume)
      else $error("pair a volumes differ while running");
   AST_LINK_SHARED: assert property (link && run[0] ##1 link && run[0] |=> vol_b_o == vol_a_o)
      else $error("link mode volumes not shared");
   AST_MANUAL_PASS: assert property (!link && !ctrl_reg[alc_pkg::CTRL_EN_A] |=> vol_a_o == $past(man_reg[0]))
      else $error("manual volume not passed through");
   AST_ONE_STEP_CUT: assert property (s_cut_one |=> vol_reg[0] == 8'($past(vol_reg[0]) - 8'h01))
      else $error("immediate limiter step not one code");
   AST_FAST_CLIP: assert property (sample_valid_i && run[0] && fast_hit[0] |=> state_reg[0] == alc_pkg::ST_LIMIT)
      else $error("full scale sample did not limit");
   AST_REF_CAP: assert property (s_raise |-> vol_reg[0] <= set_eff[0].ref_lvl)
      else $error("recovery passed reference level");
   AST_BAND_RESTART: assert property (sample_valid_i && run[0] && !fast_hit[0] && band_g[0]
      && state_reg[0] == alc_pkg::ST_WAIT |=> wait_cnt_reg[0] == 15'h0000)
      else $error("band did not restart waiting timer");
   AST_LIMIT_ENDS: assert property (sample_valid_i && run[0] && state_reg[0] == alc_pkg::ST_LIMIT
      && !over_g[0] && !fast_hit[0] |=> state_reg[0] == alc_pkg::ST_WAIT)
      else $error("limiting did not end below threshold");
   AST_BIAS_PIN: assert property (ctrl_reg[alc_pkg::CTRL_BIAS_A] |=> mic_bias_out_a_oe_o ##0 mic_bias_out_a_o)
      else $error("bias enable not driven");

endmodule

`default_nettype wire

//--- sim/alc_level_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none

module alc_level_ctrl_bench;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic sys_clk_i;
   logic reset_i;
   logic psel_i;
   logic penable_i;
   logic pwrite_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic sample_valid_i;
   alc_pkg::alc_samples_t samples_i;
   alc_pkg::alc_vol_t vol_a_o;
   alc_pkg::alc_vol_t vol_b_o;
   wire [3:0] bias;
   int n_fail = 0;
   int tests_run = 0;
   logic [31:0] rng = 32'h0000c5eb;
   logic [31:0] rdat;
   logic rerr;
   logic [15:0] v;
   logic [7:0] ra [5] = '{alc_pkg::OFS_CTRL, alc_pkg::OFS_SET_A, alc_pkg::OFS_SET_B, alc_pkg::OFS_MAN_A,
      alc_pkg::OFS_MAN_B};
   logic [31:0] rv [5] = '{32'h00000000, 32'h00384000, 32'h00384000, 32'h00009191, 32'h00009191};

   alc_level_ctrl u_alc_level_ctrl (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i), .samples_i(samples_i),
      .vol_a_o(vol_a_o), .vol_b_o(vol_b_o), .mic_bias_out_a_o(bias[0]), .mic_bias_out_a_oe_o(bias[1]),
      .mic_bias_out_b_o(bias[2]), .mic_bias_out_b_oe_o(bias[3]));

   // 10 MHz clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // ----------------------------------------------------------------
   // helpers: random source, expectations, bus and sample drivers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // detection level for each threshold code
   function automatic logic [15:0] lvl(input int c);
      case (c)
         0: return alc_pkg::LVL_M2P5;
         1: return alc_pkg::LVL_M4P1;
         2: return alc_pkg::LVL_M6P0;
         default: return alc_pkg::LVL_M8P5;
      endcase
   endfunction

   // settings word: threshold, zero-cross disable, step, recovery step, speed, reference
   function automatic logic [31:0] setw(input int th, input int zd, input int at, input int rs, input int fs,
      input logic [7:0] rf);
      return {10'h000, rf, 2'(fs), 2'(rs), 3'h0, 2'h0, 2'(at), 1'(zd), 2'(th)};
   endfunction

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; the request stands until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      k = 0;
      do
      begin
         @(posedge sys_clk_i);
         k++;
      end
      while (pready_o !== 1'b1 && k < 20);
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1)
      begin
         n_fail++;
         $display("ERROR pready expected 1 seen %b", pready_o);
         wrap_up();
      end
   endtask

   // one sample period; returns once the volume outputs have settled
   task automatic send(input logic [15:0] al, input logic [15:0] ar, input logic [15:0] bl, input logic [15:0] br);
      @(posedge sys_clk_i);
      sample_valid_i <= 1'b1;
      samples_i <= {br, bl, ar, al};
      @(posedge sys_clk_i);
      sample_valid_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      reset_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h00000000;
      sample_valid_i = 1'b0;
      samples_i = 64'h0;
      repeat (12) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      chk("vol_a reset", 32'h00009191, {16'h0000, vol_a_o});
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, ra[i], 32'h00000000);
         chk("reg reset", rv[i], rdat);
      end
      apb(1'b0, 8'h18, 32'h00000000);
      chk("unmapped err", 32'h00000001, {31'h0, rerr});
      $display("test reset done");
      // every bias enable combination, driven and enabled together
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, alc_pkg::OFS_CTRL, 32'(m) << 4);
         repeat (3) @(posedge sys_clk_i);
         chk("bias", {28'h0, m[1], m[1], m[0], m[0]}, {28'h0, bias});
      end
      $display("test bias done");
      // each threshold code: one below stays, at or above steps once, forced to 1 step
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000000);
         apb(1'b1, alc_pkg::OFS_SET_A, setw(c, 1, 3, 0, 0, 8'he1));
         apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000301);
         send(lvl(c) - 16'h0001, 16'h0010, 16'h7000, 16'h7000);
         chk("below level", 32'h00009191, {16'h0000, vol_a_o});
         v = lvl(c) + 16'(rnd() & 32'h00000fff);
         send(16'h0010, v, 16'h7000, 16'h7000);
         chk("limit step", 32'h00009090, {16'h0000, vol_a_o});
         chk("pair b idle", 32'h00009191, {16'h0000, vol_b_o});
         send(16'h0010, -v, 16'h0010, 16'h0010);
         chk("keep limiting", 32'h00008f8f, {16'h0000, vol_a_o});
      end
      $display("test limiter done");
      // linked: pair a settings rule, a pair b channel triggers the shared volume
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000000);
      apb(1'b1, alc_pkg::OFS_SET_A, setw(3, 1, 0, 0, 0, 8'he1));
      apb(1'b1, alc_pkg::OFS_SET_B, setw(0, 0, 3, 0, 0, 8'he1));
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000f04); // link set with enables off, all powered
      send(16'h0010, 16'h0010, 16'h0010, 16'h0010);
      send(16'h0010, 16'h0010, 16'h0010, 16'h4000);
      chk("link a", 32'h00009090, {16'h0000, vol_a_o});
      chk("link b", 32'h00009090, {16'h0000, vol_b_o});
      $display("test link done");
      // recovery with reference at the start code, band sample restarts the wait
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000000); // link and all power leave together
      apb(1'b1, alc_pkg::OFS_SET_A, setw(0, 1, 0, 1, 3, 8'h91));
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000301);
      send(16'h6000, 16'h0010, 16'h0000, 16'h0000);
      chk("recover start", 32'h00009090, {16'h0000, vol_a_o});
      for (int i = 0; i < 500; i++)
      begin
         v = (i == 100) ? 16'h5000 : 16'(rnd() & 32'h0000007f) | 16'h0001;
         send((i % 2) ? -v : v, 16'h0001, 16'h0000, 16'h0000);
         if (i == 90 || i == 200)
         begin
            chk("still waiting", 32'h00009090, {16'h0000, vol_a_o});
         end
         chk("ref cap", 32'h00000001, {31'h0, vol_a_o.left_volume <= 8'h91});
      end
      chk("recovered", 32'h00009191, {16'h0000, vol_a_o});
      $display("test recovery done");
      // zero-cross on: a step waits for a crossing, full scale cuts at once, timeout forces a step
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000000);
      apb(1'b1, alc_pkg::OFS_SET_A, setw(1, 0, 2, 0, 0, 8'he1));
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000309);
      send(16'h0010, 16'h0010, 16'h0000, 16'h0000);
      send(16'h6000, 16'h0010, 16'h0000, 16'h0000);
      chk("no crossing", 32'h00009191, {16'h0000, vol_a_o});
      send(16'ha000, 16'h0010, 16'h0000, 16'h0000);
      chk("crossing step", 32'h00008d8d, {16'h0000, vol_a_o});
      send(16'h7fff, 16'h0010, 16'h0000, 16'h0000);
      chk("fast cut", 32'h00008c8c, {16'h0000, vol_a_o});
      for (int j = 0; j < 128; j++)
      begin
         send(16'h6000, 16'h0010, 16'h0000, 16'h0000);
         if (j == 126)
         begin
            chk("before timeout", 32'h00008c8c, {16'h0000, vol_a_o});
         end
      end
      chk("timeout step", 32'h00008888, {16'h0000, vol_a_o});
      $display("test zero cross done");
      // a one-sample burst is an impulse: code 10 waits 128/16 samples, not 128
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000000);
      apb(1'b1, alc_pkg::OFS_SET_A, setw(0, 1, 0, 0, 2, 8'he1));
      apb(1'b1, alc_pkg::OFS_CTRL, 32'h00000301);
      send(16'h6000, 16'h0010, 16'h0000, 16'h0000);
      for (int j = 0; j < 12; j++)
      begin
         send(j[0] ? 16'hfff0 : 16'h0010, 16'h0010, 16'h0000, 16'h0000);
      end
      chk("fast recovery", 32'h00009191, {16'h0000, vol_a_o});
      $display("test impulse done");
      wrap_up();
   end
endmodule

`default_nettype wire
